// >>> logic/rbt_buf.sv
// Two-entry valid/ready buffer, head entry held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module rbt_buf #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic [CW-1:0] wr_idx;
   logic do_push;
   logic do_pop;

   assign do_push = in_valid & in_ready;
   assign do_pop = out_valid & out_ready;
   assign wr_idx = count_q - {{(CW-1){1'b0}}, do_pop};
   assign count_d = count_q + {{(CW-1){1'b0}}, do_push} - {{(CW-1){1'b0}}, do_pop};
   assign out_data = mem_q[0];

   // Shift-out order keeps the head in a fixed flop, so out_data needs no read mux
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
         if (do_pop && (i + 1 < DEPTH)) begin
            mem_d[i] = mem_q[i + 1];
         end
         if (do_push && (wr_idx == CW'(i))) begin
            mem_d[i] = in_data;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count_q <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         count_q <= count_d;
         in_ready <= (count_d < CW'(DEPTH));
         out_valid <= (count_d != '0);
      end
   end

   always_ff @(posedge clock) begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_q[i] <= mem_d[i];
      end
   end
endmodule
`default_nettype wire

// >>> logic/rbt_pkg.sv
// Constants shared by the registered bus transceiver and its stream buffer
`default_nettype none
package rbt_pkg;
   localparam int HALF_W = 8;
   localparam int HALVES = 2;
   localparam int BUS_W = 16;
   localparam int APB_AW = 12;
   localparam int STREAM_W = 32;
   localparam int BUF_DEPTH = 2;
   // Register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STORE = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   // Control field layout, per half at base HALF_STRIDE*h
   localparam int HALF_STRIDE = 4;
   localparam int CTL_B_EN = 0;
   localparam int CTL_A_EN_N = 1;
   localparam int CTL_B_SEL = 2;
   localparam int CTL_A_SEL = 3;
   localparam int CTL_GANG = 8;
   localparam int CTL_W = 9;
   // Both ports undriven, live data selected, halves independent
   localparam logic [8:0] CTRL_RESET = 9'h022;
   // Status field layout
   localparam int ST_OVERRUN = 0;
   localparam int ST_OUT_VALID = 1;
   localparam int ST_IN_READY = 2;
   localparam int ST_GANG = 3;
endpackage
`default_nettype wire

// >>> logic/rbt_transceiver.sv
// Registered bidirectional transceiver: two 8-bit halves, APB control
// Overview of operation
// - Two independent 8-bit halves, optionally ganged
// - Capture edge always loads that direction's register
// - Select low passes live, high passes stored
// - Live/stored switch never glitches the output
// - B drives on enable high, A on low
// - Both live and driven: each bus latches itself
// - Stored B drive lets A data fill both
// - Stored A drive lets B data fill both
// - Data inputs keep last level when undriven
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rbt_transceiver
   import rbt_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] a_side_data_port_i,
   output logic [15:0] a_side_data_port_o,
   output logic [15:0] a_side_data_port_oe,
   input wire logic [15:0] b_side_data_port_i,
   output logic [15:0] b_side_data_port_o,
   output logic [15:0] b_side_data_port_oe,
   input wire logic [1:0] a_to_b_capture_clock,
   input wire logic [1:0] b_to_a_capture_clock,
   output logic stream_valid,
   input wire logic stream_ready,
   output logic [31:0] stream_data
);
   // Control bit of a half; a ganged pair runs from the low half's fields
   function automatic logic ctl_bit(input logic [8:0] c, input int h, input int f);
      int base;
      base = (c[CTL_GANG] ? 0 : h) * HALF_STRIDE;
      return c[base + f];
   endfunction

   logic [8:0] ctrl_q;
   logic overrun_q;
   logic [15:0] a_s1_q, a_s2_q, a_keep_q;
   logic [15:0] b_s1_q, b_s2_q, b_keep_q;
   logic [1:0] cab_s1_q, cab_s2_q, cab_s3_q;
   logic [1:0] cba_s1_q, cba_s2_q, cba_s3_q;
   logic [1:0] cab_rise, cba_rise;
   logic [15:0] ab_q, ba_q, ab_d, ba_d;
   logic [15:0] b_src, a_src;
   logic [1:0] b_en, a_en_n, b_sel, a_sel;
   logic cap_any;
   logic buf_in_ready;
   logic apb_access, apb_done, wr_done;
   logic hit_ctrl, hit_store, hit_status, hit_any;
   logic [31:0] rdata;

   // Pins come from outside the clock domain: two flops before any use
   always_ff @(posedge clock) begin
      a_s1_q <= a_side_data_port_i;
      a_s2_q <= a_s1_q;
      b_s1_q <= b_side_data_port_i;
      b_s2_q <= b_s1_q;
      cab_s1_q <= a_to_b_capture_clock;
      cab_s2_q <= cab_s1_q;
      cab_s3_q <= cab_s2_q;
      cba_s1_q <= b_to_a_capture_clock;
      cba_s2_q <= cba_s1_q;
      cba_s3_q <= cba_s2_q;
   end

   // Keeper stage: last settled level of each data line is what the logic sees
   always_ff @(posedge clock) begin
      a_keep_q <= a_s2_q;
      b_keep_q <= b_s2_q;
   end

   genvar h;
   generate
      for (h = 0; h < HALVES; h++) begin : g_half
         localparam int LO = h * HALF_W;
         localparam int CK = (h == 0) ? 0 : 1;
         // Ganged mode uses the low half's capture clocks for both halves
         assign cab_rise[h] = ctrl_q[CTL_GANG] ? (cab_s2_q[0] & ~cab_s3_q[0])
                                               : (cab_s2_q[CK] & ~cab_s3_q[CK]);
         assign cba_rise[h] = ctrl_q[CTL_GANG] ? (cba_s2_q[0] & ~cba_s3_q[0])
                                               : (cba_s2_q[CK] & ~cba_s3_q[CK]);
         assign b_en[h] = ctl_bit(ctrl_q, h, CTL_B_EN);
         assign a_en_n[h] = ctl_bit(ctrl_q, h, CTL_A_EN_N);
         assign b_sel[h] = ctl_bit(ctrl_q, h, CTL_B_SEL);
         assign a_sel[h] = ctl_bit(ctrl_q, h, CTL_A_SEL);
         // Capture ignores selects and enables
         assign ab_d[LO +: HALF_W] = cab_rise[h] ? a_keep_q[LO +: HALF_W]
                                                 : ab_q[LO +: HALF_W];
         assign ba_d[LO +: HALF_W] = cba_rise[h] ? b_keep_q[LO +: HALF_W]
                                                 : ba_q[LO +: HALF_W];
         assign b_src[LO +: HALF_W] = b_sel[h] ? ab_q[LO +: HALF_W]
                                               : a_keep_q[LO +: HALF_W];
         assign a_src[LO +: HALF_W] = a_sel[h] ? ba_q[LO +: HALF_W]
                                               : b_keep_q[LO +: HALF_W];

         // Outputs are registered after the source mux, so a select change
         // moves the pin once per clock and can never show a decode spike.
         // With both sides live and driven each pin echoes the opposite keeper,
         // which closes a loop that holds the bus at its last level.
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               b_side_data_port_o[LO +: HALF_W] <= '0;
               a_side_data_port_o[LO +: HALF_W] <= '0;
               b_side_data_port_oe[LO +: HALF_W] <= '0;
               a_side_data_port_oe[LO +: HALF_W] <= '0;
            end else begin
               b_side_data_port_o[LO +: HALF_W] <= b_src[LO +: HALF_W];
               a_side_data_port_o[LO +: HALF_W] <= a_src[LO +: HALF_W];
               b_side_data_port_oe[LO +: HALF_W] <= {HALF_W{b_en[h]}};
               a_side_data_port_oe[LO +: HALF_W] <= {HALF_W{~a_en_n[h]}};
            end
         end

         property p_cap_ab;
            @(posedge clock) disable iff (!rst_n)
            cab_rise[h] |=> ab_q[LO +: HALF_W] == $past(a_keep_q[LO +: HALF_W]);
         endproperty
         a_cap_ab: assert property (p_cap_ab) else $error("a-to-b capture missed");

         property p_cap_ba;
            @(posedge clock) disable iff (!rst_n)
            (cba_rise[h] && a_sel[h]) |=> ba_q[LO +: HALF_W] == $past(b_keep_q[LO +: HALF_W])
               ##1 a_side_data_port_o[LO +: HALF_W] == $past(b_keep_q[LO +: HALF_W], 2);
         endproperty
         a_cap_ba: assert property (p_cap_ba) else $error("stored b not on a");

         property p_b_live;
            @(posedge clock) disable iff (!rst_n)
            !b_sel[h] |=> b_side_data_port_o[LO +: HALF_W] == $past(a_keep_q[LO +: HALF_W]);
         endproperty
         a_b_live: assert property (p_b_live) else $error("b port not live");

         property p_b_stored;
            @(posedge clock) disable iff (!rst_n)
            (b_sel[h] && !cab_rise[h])
               |=> b_side_data_port_o[LO +: HALF_W] == ab_q[LO +: HALF_W];
         endproperty
         a_b_stored: assert property (p_b_stored) else $error("b port not stored");

         property p_b_oe;
            @(posedge clock) disable iff (!rst_n)
            b_side_data_port_oe[LO] |-> $past(b_en[h]);
         endproperty
         a_b_oe: assert property (p_b_oe) else $error("b driven while disabled");

         property p_a_oe;
            @(posedge clock) disable iff (!rst_n)
            $changed(a_en_n[h])
               |=> a_side_data_port_oe[LO +: HALF_W] == {HALF_W{~$past(a_en_n[h])}};
         endproperty
         a_a_oe: assert property (p_a_oe) else $error("a enable not followed");
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ab_q <= '0;
         ba_q <= '0;
      end else begin
         ab_q <= ab_d;
         ba_q <= ba_d;
      end
   end

   // Every capture is also offered to the stream; a full buffer drops the word
   // and leaves a sticky overrun, the pin register itself still loads
   assign cap_any = (|cab_rise) | (|cba_rise);

   rbt_buf #(
      .WIDTH(STREAM_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(cap_any),
      .in_ready(buf_in_ready),
      .in_data({ba_d, ab_d}),
      .out_valid(stream_valid),
      .out_ready(stream_ready),
      .out_data(stream_data)
   );

   // APB slave: ready comes one cycle into the access phase
   assign apb_access = psel & penable & ~pready;
   assign apb_done = psel & penable & pready;
   assign hit_ctrl = (paddr == ADDR_CTRL);
   assign hit_store = (paddr == ADDR_STORE);
   assign hit_status = (paddr == ADDR_STATUS);
   assign hit_any = hit_ctrl | hit_store | hit_status;
   assign wr_done = apb_done & pwrite;
   assign rdata = hit_ctrl ? {23'h000000, ctrl_q} :
                  hit_store ? {ba_q, ab_q} :
                  hit_status ? {28'h0000000, ctrl_q[CTL_GANG], buf_in_ready,
                                stream_valid, overrun_q} : 32'h00000000;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= apb_access;
         pslverr <= apb_access & ~hit_any;
         prdata <= (apb_access & ~pwrite) ? rdata : 32'h00000000;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_done && hit_ctrl) begin
         ctrl_q <= pwdata[CTL_W-1:0];
      end
   end

   // Set wins over a same-cycle write-one-to-clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         overrun_q <= 1'b0;
      end else if (cap_any && !buf_in_ready) begin
         overrun_q <= 1'b1;
      end else if (wr_done && hit_status && pwdata[ST_OVERRUN]) begin
         overrun_q <= 1'b0;
      end
   end

   property p_reset_idle;
      @(posedge clock) disable iff (!rst_n)
      $rose(rst_n) |-> (a_side_data_port_oe == '0) && (b_side_data_port_oe == '0);
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("port driven after reset");

   property p_gang;
      @(posedge clock) disable iff (!rst_n)
      (ctrl_q[CTL_GANG] && $past(ctrl_q[CTL_GANG]))
         |-> b_side_data_port_oe[15:8] == b_side_data_port_oe[7:0];
   endproperty
   a_gang: assert property (p_gang) else $error("ganged halves differ");

   property p_overrun;
      @(posedge clock) disable iff (!rst_n)
      (cap_any && !buf_in_ready) |=> overrun_q;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_overrun_hold;
      @(posedge clock) disable iff (!rst_n)
      (overrun_q && !(wr_done && hit_status && pwdata[ST_OVERRUN])) |=> overrun_q;
   endproperty
   a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost");

   property p_pready_pulse;
      @(posedge clock) disable iff (!rst_n)
      pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");

   property p_slverr_ready;
      @(posedge clock) disable iff (!rst_n)
      pslverr |-> pready;
   endproperty
   a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr without pready");

   property p_prdata_idle;
      @(posedge clock) disable iff (!rst_n)
      !pready |-> prdata == 32'h00000000;
   endproperty
   a_prdata_idle: assert property (p_prdata_idle) else $error("prdata outside access");

   property p_ctrl_write;
      @(posedge clock) disable iff (!rst_n)
      (wr_done && hit_ctrl) |=> ctrl_q == $past(pwdata[CTL_W-1:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_a_live;
      @(posedge clock) disable iff (!rst_n)
      !a_sel[0] |=> a_side_data_port_o[7:0] == $past(b_keep_q[7:0]);
   endproperty
   a_a_live: assert property (p_a_live) else $error("a port not live");

   property p_a_stored;
      @(posedge clock) disable iff (!rst_n)
      (a_sel[0] && !cba_rise[0]) |=> a_side_data_port_o[7:0] == ba_q[7:0];
   endproperty
   a_a_stored: assert property (p_a_stored) else $error("a port not stored");

   property p_b_oe_follow;
      @(posedge clock) disable iff (!rst_n)
      b_en[0] |=> b_side_data_port_oe[7:0] == 8'hff;
   endproperty
   a_b_oe_follow: assert property (p_b_oe_follow) else $error("b enable not followed");

   property p_echo;
      @(posedge clock) disable iff (!rst_n)
      (!a_sel[1] && !b_sel[1] && b_en[1] && !a_en_n[1])
         |=> (a_side_data_port_oe[15:8] == 8'hff) && (b_side_data_port_oe[15:8] == 8'hff);
   endproperty
   a_echo: assert property (p_echo) else $error("live pair not driven both ways");

   // A stalled receiver must see the same head word until it takes it
   property p_stream_hold;
      @(posedge clock) disable iff (!rst_n)
      (stream_valid && !stream_ready) |=> stream_valid && $stable(stream_data);
   endproperty
   a_stream_hold: assert property (p_stream_hold) else $error("stream head lost");
endmodule
`default_nettype wire

// >>> test/rbt_bus_model.sv
// Far-side bus logic: resolves one data bus, held at its last level
`timescale 1ns/1ps
`default_nettype none
module rbt_bus_model (
   input wire logic [15:0] dev_o,
   input wire logic [15:0] dev_oe,
   input wire logic [15:0] ext_o,
   input wire logic [15:0] ext_oe,
   output logic [15:0] wire_lvl
);
   initial wire_lvl = 16'h0000;
   // No pull on the bus: an undriven line keeps whatever was last driven
   always @* begin
      for (int i = 0; i < 16; i++) begin
         if (dev_oe[i] && ext_oe[i] && dev_o[i] !== ext_o[i]) wire_lvl[i] = 1'bx;
         else if (dev_oe[i]) wire_lvl[i] = dev_o[i];
         else if (ext_oe[i]) wire_lvl[i] = ext_o[i];
      end
   end
endmodule
`default_nettype wire

// >>> test/tb_registered_bidir_transceiver.sv
// Self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module tb_registered_bidir_transceiver;
   import rbt_pkg::*;
   logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stream_ready = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, stream_data, rd;
   logic pready, pslverr, stream_valid, err;
   logic [15:0] a_i, a_o, a_oe, b_i, b_o, b_oe, ea = 16'h0, eaoe = 16'h0;
   logic [15:0] eb = 16'h0, eboe = 16'h0;
   logic [1:0] cab = 2'b00, cba = 2'b00;
   int errors = 0, cmp_count = 0, cyc = 0, seed = 32'he20971e4;
   int ab = 0, ba = 0;
   int q[$];
   logic [15:0] va, vb;
   always #25 clock = ~clock;
   rbt_transceiver uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .a_side_data_port_i(a_i), .a_side_data_port_o(a_o),
      .a_side_data_port_oe(a_oe), .b_side_data_port_i(b_i), .b_side_data_port_o(b_o),
      .b_side_data_port_oe(b_oe), .a_to_b_capture_clock(cab), .b_to_a_capture_clock(cba),
      .stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data));
   rbt_bus_model bus_a (.dev_o(a_o), .dev_oe(a_oe), .ext_o(ea), .ext_oe(eaoe), .wire_lvl(a_i));
   rbt_bus_model bus_b (.dev_o(b_o), .dev_oe(b_oe), .ext_o(eb), .ext_oe(eboe),
      .wire_lvl(b_i));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One APB transfer; waits for pready, then releases the request
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge clock);
      psel <= 1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1;
      // Read at the falling edge: the value the next rising edge samples
      do begin
         @(negedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      @(posedge clock);
      psel <= 0;
      penable <= 0;
   endtask
   // Pulse width and data hold of three clocks or more on each side
   task automatic pulse(input bit to_b, input int h);
      if (to_b) cab[h] <= 1; else cba[h] <= 1;
      repeat (4) @(posedge clock);
      if (to_b) cab[h] <= 0; else cba[h] <= 0;
      repeat (4) @(posedge clock);
      if (to_b) ab[8*h+:8] = a_i[8*h+:8]; else ba[8*h+:8] = b_i[8*h+:8];
      if (q.size() < BUF_DEPTH) q.push_back({ba[15:0], ab[15:0]});
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc > 3000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      chk("a_oe", 0, a_oe);
      chk("b_oe", 0, b_oe);
      apb(0, ADDR_CTRL, 0);
      chk("ctrl", 32'h22, rd);
      apb(0, 12'h00c, 0);
      chk("slverr", 1, err);
      $display("test reset done");
      va = $random(seed);
      ea <= va; eaoe <= 16'hffff;
      apb(1, ADDR_CTRL, 32'h33);
      repeat (6) @(posedge clock);
      chk("b_oe", 16'hffff, b_oe);
      chk("a_oe", 0, a_oe);
      chk("b live", va, b_o);
      $display("test live done");
      apb(1, ADDR_CTRL, 32'h37);
      pulse(1, 0);
      vb = $random(seed);
      ea <= vb;
      repeat (6) @(posedge clock);
      chk("b mixed", {vb[15:8], va[7:0]}, b_o);
      $display("test stored done");
      ea <= ~vb;
      repeat (4) @(posedge clock);
      pulse(1, 0);
      repeat (5) @(posedge clock);
      pulse(0, 0);
      apb(0, ADDR_STORE, 0);
      chk("store", {ba[15:0], ab[15:0]}, rd);
      chk("copy", ab[7:0], ba[7:0]);
      apb(0, ADDR_STATUS, 0);
      chk("status full", 32'h3, rd);
      apb(1, ADDR_STATUS, 32'h1);
      apb(0, ADDR_STATUS, 0);
      chk("status clr", 32'h2, rd);
      stream_ready <= 1;
      for (int n = 0; n < 20 && q.size() > 0; n++) begin
         @(negedge clock);
         if (stream_valid === 1'b1) chk("stream", q.pop_front(), stream_data);
      end
      chk("drained", 0, q.size());
      repeat (2) @(posedge clock);
      chk("stream idle", 0, stream_valid);
      $display("test capture done");
      vb = $random(seed);
      eaoe <= 16'h0;
      apb(1, ADDR_CTRL, 32'h08);
      // Let the device release B before the far side drives it
      repeat (2) @(posedge clock);
      eb <= vb;
      eboe <= 16'hffff;
      repeat (4) @(posedge clock);
      pulse(0, 0);
      repeat (5) @(posedge clock);
      pulse(1, 0);
      chk("b copy", vb[7:0], ab[7:0]);
      apb(0, ADDR_STORE, 0);
      chk("store b", {ba[15:0], ab[15:0]}, rd);
      $display("test copy b done");
      eboe <= 16'h0;
      apb(1, ADDR_CTRL, 32'h33);
      repeat (2) @(posedge clock);
      vb = $random(seed);
      ea <= vb;
      eaoe <= 16'hffff;
      repeat (6) @(posedge clock);
      apb(1, ADDR_CTRL, 32'h12);
      repeat (10) @(posedge clock);
      eaoe <= 16'h0;
      repeat (10) @(posedge clock);
      chk("a hold", vb[15:8], a_i[15:8]);
      chk("b hold", vb[15:8], b_i[15:8]);
      chk("iso oe", 0, {a_oe[7:0], b_oe[7:0]});
      $display("test reinforce done");
      apb(1, ADDR_CTRL, 32'h103);
      repeat (4) @(posedge clock);
      chk("gang oe", 16'hffff, b_oe);
      pulse(1, 0);
      ab[15:8] = a_i[15:8];
      apb(0, ADDR_STORE, 0);
      chk("gang store", {ba[15:0], ab[15:0]}, rd);
      apb(0, ADDR_STATUS, 0);
      chk("status gang", 32'hc, rd);
      $display("test gang done");
      print_verdict();
   end
endmodule
`default_nettype wire
